/* File: common/pfe_pkg.sv */
// shared constants and types of the port function and edge interrupt block
package pfe_pkg;

  localparam int PFE_ADDR_W = 8;
  localparam int PFE_IDX_W = 6;

  // register indices; byte address is four times the index
  localparam logic [PFE_IDX_W-1:0] PFE_IDX_PORT2_FUNC = 6'h0D;
  localparam logic [PFE_IDX_W-1:0] PFE_IDX_PORT3_FUNC = 6'h0F;
  localparam logic [PFE_IDX_W-1:0] PFE_IDX_INPUT_PULL = 6'h1A;
  localparam logic [PFE_IDX_W-1:0] PFE_IDX_INPUT_LEVEL = 6'h1B;
  localparam logic [PFE_IDX_W-1:0] PFE_IDX_DRAIN_DATA = 6'h1C;
  localparam logic [PFE_IDX_W-1:0] PFE_IDX_EDGE_SEL_LOW = 6'h1D;
  localparam logic [PFE_IDX_W-1:0] PFE_IDX_EDGE_SEL_HIGH = 6'h1E;
  localparam logic [PFE_IDX_W-1:0] PFE_IDX_PORT2_DIR = 6'h20;
  localparam logic [PFE_IDX_W-1:0] PFE_IDX_PORT3_DIR = 6'h21;
  localparam logic [PFE_IDX_W-1:0] PFE_IDX_PORT2_OUT = 6'h22;
  localparam logic [PFE_IDX_W-1:0] PFE_IDX_PORT3_OUT = 6'h23;
  localparam logic [PFE_IDX_W-1:0] PFE_IDX_IRQ_ENABLE = 6'h24;
  localparam logic [PFE_IDX_W-1:0] PFE_IDX_IRQ_STATUS = 6'h25;
  localparam logic [PFE_IDX_W-1:0] PFE_IDX_MASTER_IRQ = 6'h26;
  localparam logic [PFE_IDX_W-1:0] PFE_IDX_PORT2_LEVEL = 6'h27;
  localparam logic [PFE_IDX_W-1:0] PFE_IDX_PORT3_LEVEL = 6'h28;

  // reset values
  localparam logic [3:0] PFE_FUNC_RST = 4'h0;
  localparam logic [3:0] PFE_PULL_RST = 4'h0;
  localparam logic [3:0] PFE_DRAIN_RST = 4'hF;
  localparam logic [3:0] PFE_EDGE_SEL_RST = 4'h0;
  localparam logic [3:0] PFE_CTRL_RST = 4'h0;

  // field positions in the function select registers
  localparam int PFE_SLOWCLK_PIN_SELECT = 0;
  localparam int PFE_FASTCLK_PIN_SELECT = 1;
  localparam int PFE_SER_IN_PIN_SELECT = 0;
  localparam int PFE_TX_CLOCK_PIN_SELECT = 1;
  localparam int PFE_RX_CLOCK_PIN_SELECT = 2;
  localparam int PFE_SER_OUT_PIN_SELECT = 3;

  // bus responses
  localparam logic [1:0] PFE_RESP_OKAY = 2'h0;
  localparam logic [1:0] PFE_RESP_SLVERR = 2'h2;

  // edge select field: bit 0 arms rising, bit 1 arms falling
  typedef enum logic [1:0] {
    PFE_EDGE_OFF = 2'h0,
    PFE_EDGE_RISE = 2'h1,
    PFE_EDGE_FALL = 2'h2,
    PFE_EDGE_BOTH = 2'h3
  } pfe_edge_mode_t;

endpackage

/* File: hw/pfe_sync.sv */
// two flip-flop synchroniser for pin levels
module pfe_sync
  import pfe_pkg::*;
#(
  parameter int WIDTH = 4
) (
  // clock
  input wire logic aclk,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // no reset: the chain is pure data and settles two edges into reset
  always_ff @(posedge aclk) begin
    meta_q <= d;
  end

  always_ff @(posedge aclk) begin
    q <= meta_q;
  end

endmodule // pfe_sync

/* File: hw/pfe_edge_detect.sv */
// per-pin edge detection with selectable edge for the port 0 interrupts
module pfe_edge_detect
  import pfe_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // synchronised pin levels and two-bit mode per pin
  input wire logic [3:0] pin_level,
  input wire logic [7:0] mode,
  // one-cycle pulse per selected edge
  output logic [3:0] edge_hit
);

  logic [3:0] prev_q;

  // previous sample, loaded on every edge so no false edge follows reset
  always_ff @(posedge aclk) begin
    prev_q <= pin_level;
  end

  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_pin
      logic rise;
      logic fall;
      assign rise = pin_level[i] & ~prev_q[i];
      assign fall = ~pin_level[i] & prev_q[i];
      // 00 off, 01 rising, 10 falling, 11 both
      assign edge_hit[i] = (rise & mode[2*i]) | (fall & mode[2*i+1]);
    end
  endgenerate

  property p_rise_only;
    @(posedge aclk) disable iff (!aresetn)
    (mode[1:0] == PFE_EDGE_RISE && edge_hit[0]) |-> (pin_level[0] && !$past(pin_level[0]));
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("rise mode hit without rise");

  property p_fall_seen;
    @(posedge aclk) disable iff (!aresetn)
    (mode[3:2] == PFE_EDGE_FALL && $fell(pin_level[1])) |-> edge_hit[1];
  endproperty
  a_fall_seen: assert property (p_fall_seen) else $error("falling edge missed");

  property p_off_quiet;
    @(posedge aclk) disable iff (!aresetn)
    (mode[5:4] == PFE_EDGE_OFF) |-> !edge_hit[2];
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("disabled pin reported edge");

endmodule // pfe_edge_detect

/* File: hw/pfe_port_unit.sv */
// port function select, input and open-drain ports, edge interrupts, axi4-lite slave
// Function
// - port 2 bit 1 select outputs fast oscillator clock, pin forced output
// - port 2 bit 0 select outputs slow oscillator clock, pin forced output
// - port 3 bit 3 select outputs serial transmit data, pin forced output
// - port 3 bit 2 select is receive clock, direction from receive clock source
// - port 3 bit 1 select is transmit clock, direction from transmit clock source
// - port 3 bit 0 select feeds receive data, pin forced input
// - all function select bits reset to zero, ordinary input/output
// - input port level register reads present pin levels, read only
// - pull select bit: 0 high-impedance input, 1 pull-up input
// - open-drain data register drives pins, resets to all ones
// - open-drain pins change on second clock edge after the write
// - four port 0 pins each have disabled, rising, falling or both-edge interrupt
// - request only when selected edge with master and own enable set
// - both edge select registers reset to zero, all interrupts disabled
// - low select register: bits 3:2 interrupt 1, bits 1:0 interrupt 0
// - high select register: bits 3:2 interrupt 3, bits 1:0 interrupt 2
//
// The AXI4-Lite slave port is this design's own decision.
module pfe_port_unit
  import pfe_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [PFE_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [PFE_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // port 0 interrupt pins
  input wire logic [3:0] port0_pin_in,
  // port 2 two-way pins
  input wire logic [1:0] port2_pin_in,
  output logic [1:0] port2_pin_out,
  output logic [1:0] port2_pin_oe_n,
  // port 3 two-way pins
  input wire logic [3:0] port3_pin_in,
  output logic [3:0] port3_pin_out,
  output logic [3:0] port3_pin_oe_n,
  // input-only port
  input wire logic [3:0] port7_pin_in,
  output logic [3:0] port7_pull_en,
  // open-drain output port
  output logic [3:0] port8_pin_out,
  output logic [3:0] port8_pin_oe_n,
  // oscillator clocks to route out
  input wire logic fast_osc_clock_out,
  input wire logic slow_osc_clock_out,
  // from the serial port
  input wire logic ser_tx_data,
  input wire logic serial_receive_clock_drv,
  input wire logic serial_transmit_clock_drv,
  input wire logic receive_clock_source,
  input wire logic transmit_clock_source,
  // to the serial port
  output logic ser_rx_data,
  output logic serial_receive_clock_in,
  output logic serial_transmit_clock_in,
  // interrupt to the cpu
  output logic irq
);

  logic [3:0] port2_func_q;
  logic [3:0] port3_func_q;
  logic [3:0] pull_q;
  logic [3:0] drain_q;
  logic [3:0] sel_low_q;
  logic [3:0] sel_high_q;
  logic [1:0] port2_dir_q;
  logic [3:0] port3_dir_q;
  logic [1:0] port2_out_q;
  logic [3:0] port3_out_q;
  logic [3:0] irq_en_q;
  logic [3:0] irq_stat_q;
  logic master_irq_enable_q;
  logic [13:0] pins_s;
  logic [3:0] port0_s;
  logic [1:0] port2_s;
  logic [3:0] port3_s;
  logic [3:0] port7_s;
  logic [3:0] edge_hit;
  logic [PFE_IDX_W-1:0] aw_idx_q;
  logic [3:0] wdata_q;
  logic wstrb0_q;
  logic wr_do;
  logic wr_ok;
  logic [PFE_IDX_W-1:0] ar_idx;
  logic [3:0] rd_data;
  logic rd_ok;

  pfe_sync #(
    .WIDTH(14)
  ) u_sync (
    .aclk(aclk),
    .d({port0_pin_in, port2_pin_in, port3_pin_in, port7_pin_in}),
    .q(pins_s)
  );

  assign port0_s = pins_s[13:10];
  assign port2_s = pins_s[9:8];
  assign port3_s = pins_s[7:4];
  assign port7_s = pins_s[3:0];

  pfe_edge_detect u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_level(port0_s),
    .mode({sel_high_q, sel_low_q}),
    .edge_hit(edge_hit)
  );

  // write channel: address and data taken in either order, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_idx_q <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_idx_q <= awaddr[PFE_ADDR_W-1:2];
    end else if (wr_do) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      wdata_q <= 4'h0;
      wstrb0_q <= 1'b0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      wdata_q <= wdata[3:0];
      wstrb0_q <= wstrb[0];
    end else if (wr_do) begin
      wready <= 1'b1;
    end
  end

  assign wr_do = !awready && !wready && !bvalid;

  always_comb begin
    if (aw_idx_q == PFE_IDX_PORT2_FUNC) begin
      wr_ok = 1'b1;
    end else if (aw_idx_q == PFE_IDX_PORT3_FUNC || aw_idx_q == PFE_IDX_INPUT_PULL) begin
      wr_ok = 1'b1;
    end else if (aw_idx_q == PFE_IDX_INPUT_LEVEL || aw_idx_q == PFE_IDX_DRAIN_DATA) begin
      wr_ok = 1'b1;
    end else if (aw_idx_q == PFE_IDX_EDGE_SEL_LOW || aw_idx_q == PFE_IDX_EDGE_SEL_HIGH) begin
      wr_ok = 1'b1;
    end else if (aw_idx_q >= PFE_IDX_PORT2_DIR && aw_idx_q <= PFE_IDX_PORT3_LEVEL) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= PFE_RESP_OKAY;
    end else if (wr_do) begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? PFE_RESP_OKAY : PFE_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // function selects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port2_func_q <= PFE_FUNC_RST;
      port3_func_q <= PFE_FUNC_RST;
    end else if (wr_do && wstrb0_q) begin
      if (aw_idx_q == PFE_IDX_PORT2_FUNC) begin
        port2_func_q <= {2'h0, wdata_q[1:0]};
      end else if (aw_idx_q == PFE_IDX_PORT3_FUNC) begin
        port3_func_q <= wdata_q;
      end
    end
  end

  // port 2 and 3 direction and output data, 1 means output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port2_dir_q <= 2'h0;
      port3_dir_q <= PFE_CTRL_RST;
      port2_out_q <= 2'h0;
      port3_out_q <= PFE_CTRL_RST;
    end else if (wr_do && wstrb0_q) begin
      if (aw_idx_q == PFE_IDX_PORT2_DIR) begin
        port2_dir_q <= wdata_q[1:0];
      end else if (aw_idx_q == PFE_IDX_PORT3_DIR) begin
        port3_dir_q <= wdata_q;
      end else if (aw_idx_q == PFE_IDX_PORT2_OUT) begin
        port2_out_q <= wdata_q[1:0];
      end else if (aw_idx_q == PFE_IDX_PORT3_OUT) begin
        port3_out_q <= wdata_q;
      end
    end
  end

  // input port pull select and open-drain data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pull_q <= PFE_PULL_RST;
      drain_q <= PFE_DRAIN_RST;
    end else if (wr_do && wstrb0_q) begin
      if (aw_idx_q == PFE_IDX_INPUT_PULL) begin
        pull_q <= wdata_q;
      end else if (aw_idx_q == PFE_IDX_DRAIN_DATA) begin
        drain_q <= wdata_q;
      end
    end
  end

  // edge selects and interrupt enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_low_q <= PFE_EDGE_SEL_RST;
      sel_high_q <= PFE_EDGE_SEL_RST;
      irq_en_q <= PFE_CTRL_RST;
      master_irq_enable_q <= 1'b0;
    end else if (wr_do && wstrb0_q) begin
      if (aw_idx_q == PFE_IDX_EDGE_SEL_LOW) begin
        sel_low_q <= wdata_q;
      end else if (aw_idx_q == PFE_IDX_EDGE_SEL_HIGH) begin
        sel_high_q <= wdata_q;
      end else if (aw_idx_q == PFE_IDX_IRQ_ENABLE) begin
        irq_en_q <= wdata_q;
      end else if (aw_idx_q == PFE_IDX_MASTER_IRQ) begin
        master_irq_enable_q <= wdata_q[0];
      end
    end
  end

  // sticky request flags; a new edge wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= PFE_CTRL_RST;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (edge_hit[i] && master_irq_enable_q && irq_en_q[i]) begin
          irq_stat_q[i] <= 1'b1;
        end else if (wr_do && wstrb0_q && aw_idx_q == PFE_IDX_IRQ_STATUS && wdata_q[i]) begin
          irq_stat_q[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= master_irq_enable_q && |(irq_stat_q & irq_en_q);
    end
  end

  // read channel
  assign ar_idx = araddr[PFE_ADDR_W-1:2];

  always_comb begin
    rd_ok = 1'b1;
    if (ar_idx == PFE_IDX_PORT2_FUNC) begin
      rd_data = port2_func_q;
    end else if (ar_idx == PFE_IDX_PORT3_FUNC) begin
      rd_data = port3_func_q;
    end else if (ar_idx == PFE_IDX_INPUT_PULL) begin
      rd_data = pull_q;
    end else if (ar_idx == PFE_IDX_INPUT_LEVEL) begin
      rd_data = port7_s;
    end else if (ar_idx == PFE_IDX_DRAIN_DATA) begin
      rd_data = drain_q;
    end else if (ar_idx == PFE_IDX_EDGE_SEL_LOW) begin
      rd_data = sel_low_q;
    end else if (ar_idx == PFE_IDX_EDGE_SEL_HIGH) begin
      rd_data = sel_high_q;
    end else if (ar_idx == PFE_IDX_PORT2_DIR) begin
      rd_data = {2'h0, port2_dir_q};
    end else if (ar_idx == PFE_IDX_PORT3_DIR) begin
      rd_data = port3_dir_q;
    end else if (ar_idx == PFE_IDX_PORT2_OUT) begin
      rd_data = {2'h0, port2_out_q};
    end else if (ar_idx == PFE_IDX_PORT3_OUT) begin
      rd_data = port3_out_q;
    end else if (ar_idx == PFE_IDX_IRQ_ENABLE) begin
      rd_data = irq_en_q;
    end else if (ar_idx == PFE_IDX_IRQ_STATUS) begin
      rd_data = irq_stat_q;
    end else if (ar_idx == PFE_IDX_MASTER_IRQ) begin
      rd_data = {3'h0, master_irq_enable_q};
    end else if (ar_idx == PFE_IDX_PORT2_LEVEL) begin
      rd_data = {2'h0, port2_s};
    end else if (ar_idx == PFE_IDX_PORT3_LEVEL) begin
      rd_data = port3_s;
    end else begin
      rd_data = 4'h0;
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= PFE_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {28'h000_0000, rd_data};
      rresp <= rd_ok ? PFE_RESP_OKAY : PFE_RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  // pin drivers; oe_n low while the pin is driven
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port2_pin_out <= 2'h0;
      port2_pin_oe_n <= 2'h3;
    end else begin
      port2_pin_out[1] <= port2_func_q[PFE_FASTCLK_PIN_SELECT] ? fast_osc_clock_out
                                                                : port2_out_q[1];
      port2_pin_oe_n[1] <= !(port2_func_q[PFE_FASTCLK_PIN_SELECT] || port2_dir_q[1]);
      port2_pin_out[0] <= port2_func_q[PFE_SLOWCLK_PIN_SELECT] ? slow_osc_clock_out
                                                                : port2_out_q[0];
      port2_pin_oe_n[0] <= !(port2_func_q[PFE_SLOWCLK_PIN_SELECT] || port2_dir_q[0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port3_pin_out <= 4'h0;
      port3_pin_oe_n <= 4'hF;
    end else begin
      port3_pin_out[3] <= port3_func_q[PFE_SER_OUT_PIN_SELECT] ? ser_tx_data
                                                               : port3_out_q[3];
      port3_pin_oe_n[3] <= !(port3_func_q[PFE_SER_OUT_PIN_SELECT] || port3_dir_q[3]);
      port3_pin_out[2] <= port3_func_q[PFE_RX_CLOCK_PIN_SELECT] ? serial_receive_clock_drv
                                                                : port3_out_q[2];
      port3_pin_oe_n[2] <= port3_func_q[PFE_RX_CLOCK_PIN_SELECT] ? !receive_clock_source
                                                                 : !port3_dir_q[2];
      port3_pin_out[1] <= port3_func_q[PFE_TX_CLOCK_PIN_SELECT] ? serial_transmit_clock_drv
                                                                : port3_out_q[1];
      port3_pin_oe_n[1] <= port3_func_q[PFE_TX_CLOCK_PIN_SELECT] ? !transmit_clock_source
                                                                 : !port3_dir_q[1];
      port3_pin_out[0] <= port3_out_q[0];
      port3_pin_oe_n[0] <= port3_func_q[PFE_SER_IN_PIN_SELECT] || !port3_dir_q[0];
    end
  end

  // serial port inputs come from the synchronised pin levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_rx_data <= 1'b1;
      serial_receive_clock_in <= 1'b0;
      serial_transmit_clock_in <= 1'b0;
    end else begin
      ser_rx_data <= port3_s[0];
      serial_receive_clock_in <= port3_s[2];
      serial_transmit_clock_in <= port3_s[1];
    end
  end

  // pull-ups and open-drain pins; drain pins follow the register one edge later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port7_pull_en <= PFE_PULL_RST;
      port8_pin_out <= 4'h0;
      port8_pin_oe_n <= PFE_DRAIN_RST;
    end else begin
      port7_pull_en <= pull_q;
      port8_pin_out <= 4'h0;
      port8_pin_oe_n <= drain_q;
    end
  end

  property p_fastclk_out;
    @(posedge aclk) disable iff (!aresetn)
    port2_func_q[PFE_FASTCLK_PIN_SELECT]
      |=> (!port2_pin_oe_n[1] && port2_pin_out[1] == $past(fast_osc_clock_out));
  endproperty
  a_fastclk_out: assert property (p_fastclk_out) else $error("fast clock pin not driven");

  property p_slowclk_out;
    @(posedge aclk) disable iff (!aresetn)
    port2_func_q[PFE_SLOWCLK_PIN_SELECT]
      |=> (!port2_pin_oe_n[0] && port2_pin_out[0] == $past(slow_osc_clock_out));
  endproperty
  a_slowclk_out: assert property (p_slowclk_out) else $error("slow clock pin not driven");

  property p_ser_out;
    @(posedge aclk) disable iff (!aresetn)
    port3_func_q[PFE_SER_OUT_PIN_SELECT]
      |=> (!port3_pin_oe_n[3] && port3_pin_out[3] == $past(ser_tx_data));
  endproperty
  a_ser_out: assert property (p_ser_out) else $error("serial data pin not driven");

  property p_rx_clock_dir;
    @(posedge aclk) disable iff (!aresetn)
    port3_func_q[PFE_RX_CLOCK_PIN_SELECT] |=> port3_pin_oe_n[2] == !$past(receive_clock_source);
  endproperty
  a_rx_clock_dir: assert property (p_rx_clock_dir) else $error("rx clock direction wrong");

  property p_tx_clock_dir;
    @(posedge aclk) disable iff (!aresetn)
    port3_func_q[PFE_TX_CLOCK_PIN_SELECT] |=> port3_pin_oe_n[1] == !$past(transmit_clock_source);
  endproperty
  a_tx_clock_dir: assert property (p_tx_clock_dir) else $error("tx clock direction wrong");

  property p_ser_in;
    @(posedge aclk) disable iff (!aresetn)
    port3_func_q[PFE_SER_IN_PIN_SELECT] |=> port3_pin_oe_n[0];
  endproperty
  a_ser_in: assert property (p_ser_in) else $error("serial input pin driven");

  property p_reset_values;
    @(posedge aclk)
    !aresetn |=> (port2_func_q == 4'h0 && port3_func_q == 4'h0 && drain_q == 4'hF
                  && sel_low_q == 4'h0 && sel_high_q == 4'h0);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset value");

  property p_drain_timing;
    @(posedge aclk) disable iff (!aresetn)
    (wr_do && wstrb0_q && aw_idx_q == PFE_IDX_DRAIN_DATA) |-> ##2 port8_pin_oe_n == $past(wdata_q, 2);
  endproperty
  a_drain_timing: assert property (p_drain_timing) else $error("drain pins late or wrong");

  property p_pull_follow;
    @(posedge aclk) disable iff (!aresetn)
    ##1 port7_pull_en == $past(pull_q);
  endproperty
  a_pull_follow: assert property (p_pull_follow) else $error("pull enable mismatch");

  property p_request_gate;
    @(posedge aclk) disable iff (!aresetn)
    (edge_hit[0] && master_irq_enable_q && irq_en_q[0]) |=> irq_stat_q[0] ##1 irq;
  endproperty
  a_request_gate: assert property (p_request_gate) else $error("edge request not raised");

  property p_no_request_masked;
    @(posedge aclk) disable iff (!aresetn)
    !master_irq_enable_q |=> !irq;
  endproperty
  a_no_request_masked: assert property (p_no_request_masked) else $error("irq without master");

endmodule // pfe_port_unit

/* File: verif/pfe_pins_model.sv */
// far-side pin model: resolves the two-way pins and the open-drain port
module pfe_pins_model (
  // design side
  input wire logic [1:0] p2_out,
  input wire logic [1:0] p2_oe_n,
  input wire logic [3:0] p3_out,
  input wire logic [3:0] p3_oe_n,
  input wire logic [3:0] p8_oe_n,
  // external drivers
  input wire logic [1:0] ext2,
  input wire logic [3:0] ext3,
  // resolved pin levels
  output logic [1:0] p2_lvl,
  output logic [3:0] p3_lvl,
  output logic [3:0] p8_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  assign p2_lvl = (~p2_oe_n & p2_out) | (p2_oe_n & ext2);
  assign p3_lvl = (~p3_oe_n & p3_out) | (p3_oe_n & ext3);
  // released lines float up through the pull-up
  assign p8_lvl = p8_oe_n;
endmodule // pfe_pins_model

/* File: verif/pfe_port_unit_tb_top.sv */
// testbench for the port function and edge interrupt block
module pfe_port_unit_tb_top
  import pfe_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, irq, mst, fo, so, stx, rcd, tcd, rsrc, tsrc, srx, rci, tci;
  logic [7:0] awaddr, araddr, modes;
  logic [31:0] wdata, rdata, rd_d;
  logic [1:0] bresp, rresp, sr, port2_pin_in, port2_pin_out, port2_pin_oe_n, ext2, f2;
  logic [1:0] br, d2, o2, v2, l2;
  logic [3:0] d3, o3, v3, l3, p8o;
  logic [3:0] wstrb, port0_pin_in, port3_pin_in, port3_pin_out, port3_pin_oe_n, port7_pin_in;
  logic [3:0] port7_pull_en, port8_pin_oe_n, p8l, ext3, en, rb, fb, f3;
  logic [3:0] mdl [int];
  int errors, cmp_count;

  pfe_port_unit pfe_port_unit_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .port0_pin_in, .port2_pin_in, .port2_pin_out, .port2_pin_oe_n,
    .port3_pin_in, .port3_pin_out, .port3_pin_oe_n, .port7_pin_in, .port7_pull_en,
    .port8_pin_out(p8o), .port8_pin_oe_n, .fast_osc_clock_out(fo), .slow_osc_clock_out(so),
    .ser_tx_data(stx), .serial_receive_clock_drv(rcd), .serial_transmit_clock_drv(tcd),
    .receive_clock_source(rsrc), .transmit_clock_source(tsrc), .ser_rx_data(srx),
    .serial_receive_clock_in(rci), .serial_transmit_clock_in(tci), .irq);
  pfe_pins_model pfe_pins_model_i (.p2_out(port2_pin_out), .p2_oe_n(port2_pin_oe_n), .ext2,
    .p3_out(port3_pin_out), .p3_oe_n(port3_pin_oe_n), .ext3, .p8_oe_n(port8_pin_oe_n),
    .p2_lvl(port2_pin_in), .p3_lvl(port3_pin_in), .p8_lvl(p8l));

  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr(input int i, input logic [3:0] d);
    logic a, w;
    a = 0;
    w = 0;
    @(posedge aclk);
    awaddr <= 8'(i * 4);
    wdata <= {28'h0, d};
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'h7;
    while (!(a && w)) begin
      @(posedge aclk);
      a = a || awready === 1'b1;
      w = w || wready === 1'b1;
      awvalid <= !a;
      wvalid <= !w;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    br = bresp;
    bready <= 0;
  endtask

  task automatic rd(input int i);
    @(posedge aclk);
    araddr <= 8'(i * 4);
    {arvalid, rready} <= 2'h3;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_d = rdata;
    sr = rresp;
    rready <= 0;
  endtask

  // one pin transition on all four port 0 pins, then clear the status
  task automatic edg(input logic [3:0] v, input logic [3:0] arm);
    @(posedge aclk);
    port0_pin_in <= v;
    repeat (6) @(posedge aclk);
    rd(PFE_IDX_IRQ_STATUS);
    chk("stat", rd_d, mst ? arm & en : 4'h0);
    chk("irq", irq, mst && (arm & en) != 0);
    wr(PFE_IDX_IRQ_STATUS, 4'hF);
  endtask

  initial begin
    #100000;
    errors++;
    end_sim();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, mst, en} = 0;
    {awaddr, araddr, wdata, wstrb} = 0;
    {port0_pin_in, port7_pin_in, ext2, ext3, fo, so, stx, rcd, tcd, rsrc, tsrc} = 0;
    errors = 0;
    cmp_count = 0;
    void'($urandom(67739));
    mdl = '{PFE_IDX_PORT2_FUNC: PFE_FUNC_RST, PFE_IDX_PORT3_FUNC: PFE_FUNC_RST,
      PFE_IDX_INPUT_PULL: PFE_PULL_RST, PFE_IDX_DRAIN_DATA: PFE_DRAIN_RST,
      PFE_IDX_EDGE_SEL_LOW: PFE_EDGE_SEL_RST, PFE_IDX_EDGE_SEL_HIGH: PFE_EDGE_SEL_RST,
      PFE_IDX_PORT2_DIR: PFE_CTRL_RST, PFE_IDX_PORT3_DIR: PFE_CTRL_RST,
      PFE_IDX_PORT2_OUT: PFE_CTRL_RST, PFE_IDX_PORT3_OUT: PFE_CTRL_RST};
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    // pass 0 checks reset state, later passes random settings
    for (int t = 0; t < 9; t++) begin
      if (t > 0) begin
        @(posedge aclk);
        {fo, so, stx, rcd, tcd, rsrc, tsrc, mst} <= 8'($urandom);
        // port 7 carries digital levels only, so no pin needs its pull kept off
        {port7_pin_in, ext3, en, ext2} <= 14'($urandom);
        foreach (mdl[i]) begin
          mdl[i] = 4'($urandom);
          if (i inside {PFE_IDX_PORT2_FUNC, PFE_IDX_PORT2_DIR, PFE_IDX_PORT2_OUT})
            mdl[i][3:2] = 2'h0;
          wr(i, mdl[i]);
        end
        wr(PFE_IDX_INPUT_LEVEL, 4'hF);
        mdl[PFE_IDX_DRAIN_DATA] = ~mdl[PFE_IDX_DRAIN_DATA];
        wr(PFE_IDX_DRAIN_DATA, mdl[PFE_IDX_DRAIN_DATA]);
        chk("pin8_old", p8l, 4'(~mdl[PFE_IDX_DRAIN_DATA]));
        @(negedge aclk);
      end
      f2 = mdl[PFE_IDX_PORT2_FUNC][1:0];
      f3 = mdl[PFE_IDX_PORT3_FUNC];
      d2 = mdl[PFE_IDX_PORT2_DIR][1:0];
      o2 = mdl[PFE_IDX_PORT2_OUT][1:0];
      d3 = mdl[PFE_IDX_PORT3_DIR];
      o3 = mdl[PFE_IDX_PORT3_OUT];
      // a selected pin function overrides the direction bit
      v2 = f2 | d2;
      v3 = {f3[3] | d3[3], f3[2] ? rsrc : d3[2], f3[1] ? tsrc : d3[1], ~f3[0] & d3[0]};
      l2 = v2 & {f2[1] ? fo : o2[1], f2[0] ? so : o2[0]} | ~v2 & ext2;
      l3 = v3 & {f3[3] ? stx : o3[3], f3[2] ? rcd : o3[2], f3[1] ? tcd : o3[1], o3[0]}
        | ~v3 & ext3;
      chk("pin8", p8l, mdl[PFE_IDX_DRAIN_DATA]);
      chk("p8o", p8o, 4'h0);
      chk("pull", port7_pull_en, mdl[PFE_IDX_INPUT_PULL]);
      chk("p2oe", port2_pin_oe_n, 2'(~v2));
      chk("p2", port2_pin_in, l2);
      chk("p3oe", port3_pin_oe_n, 4'(~v3));
      chk("p3", port3_pin_in, l3);
      if (f3[0]) chk("rxd", srx, ext3[0]);
      if (f3[2]) chk("rxc", rci, l3[2]);
      if (f3[1]) chk("txc", tci, l3[1]);
      foreach (mdl[i]) begin
        rd(i);
        chk("reg", rd_d, mdl[i]);
      end
      rd(PFE_IDX_INPUT_LEVEL);
      chk("lvl", rd_d, port7_pin_in);
      chk("rresp", sr, PFE_RESP_OKAY);
      rd(PFE_IDX_PORT3_LEVEL);
      chk("lvl3", rd_d, l3);
      rd(6'h3F);
      chk("resp", sr, PFE_RESP_SLVERR);
      wr(6'h3F, 4'h0);
      chk("bresp", br, PFE_RESP_SLVERR);
      wr(PFE_IDX_MASTER_IRQ, {3'h0, mst});
      chk("bresp_ok", br, PFE_RESP_OKAY);
      wr(PFE_IDX_IRQ_ENABLE, en);
      wr(PFE_IDX_IRQ_STATUS, 4'hF);
      modes = {mdl[PFE_IDX_EDGE_SEL_HIGH], mdl[PFE_IDX_EDGE_SEL_LOW]};
      for (int j = 0; j < 4; j++) begin
        rb[j] = modes[2*j];
        fb[j] = modes[2*j+1];
      end
      edg(4'hF, rb);
      edg(4'h0, fb);
      $display("test pass %0d done", t);
    end
    end_sim();
  end
endmodule // pfe_port_unit_tb_top
